// ===== rtl/l3_route_lookup.sv
`timescale 1ns/10ps
module l3_route_lookup
	import route_pkg::*;
#(
	parameter int N_IF = 4,
	parameter int N_HOST = 8,
	parameter int N_ROUTE = 8,
	parameter longint AGE_CYCLES = AGE_TICKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [N_IF*48-1:0] if_mac,
	input wire logic [N_IF-1:0] if_valid,
	input wire logic def_valid,
	input wire logic [31:0] def_next_hop,
	input wire logic pkt_valid,
	input wire logic [47:0] pkt_dmac,
	input wire logic [31:0] pkt_dip,
	input wire logic rt_wr,
	input wire logic [$clog2(N_ROUTE)-1:0] rt_idx,
	input wire logic rt_wvalid,
	input wire logic [31:0] rt_prefix,
	input wire logic [5:0] rt_len,
	input wire logic [31:0] rt_next_hop,
	input wire logic host_wr,
	input wire logic [$clog2(N_HOST)-1:0] host_idx,
	input wire logic host_wvalid,
	input wire logic [31:0] host_wip,
	input wire logic [47:0] host_wmac,
	input wire logic arp_valid,
	input wire logic [31:0] arp_sip,
	input wire logic [47:0] arp_smac,
	output logic res_valid,
	output act_t res_act,
	output logic [47:0] res_dmac,
	output logic [31:0] res_next_hop,
	output logic req_valid,
	output logic [31:0] req_tip,
	output logic [47:0] req_dmac
);
	// index slices assume power-of-two tables; other sizes could address past the end
	if (N_IF < 1 || N_HOST < 2 || N_ROUTE < 2 || AGE_CYCLES < 1 ||
		(N_HOST & (N_HOST - 1)) != 0 || (N_ROUTE & (N_ROUTE - 1)) != 0) begin : g_bad_param
		$error("l3_route_lookup: bad parameter");
	end

	logic [N_HOST-1:0] h_valid_r, h_static_r;
	logic [31:0] h_ip_r [N_HOST];
	logic [47:0] h_mac_r [N_HOST];
	logic [63:0] h_age_r [N_HOST];
	logic [N_ROUTE-1:0] r_valid_r;
	logic [31:0] r_pfx_r [N_ROUTE];
	logic [5:0] r_len_r [N_ROUTE];
	logic [31:0] r_nh_r [N_ROUTE];

	// prefix match of ip against a stored prefix of given length
	function automatic logic pfx_hit(input logic [31:0] ip, input logic [31:0] p,
		input logic [5:0] l);
		logic [31:0] m;
		m = (l == 6'h00) ? 32'h0000_0000 : (32'hFFFF_FFFF << (6'h20 - l));
		return ((ip ^ p) & m) == 32'h0000_0000;
	endfunction

	// host search by ip, used for lookup, next-hop resolution and learning
	function automatic logic [N_HOST:0] host_find(input logic [31:0] ip,
		input logic [N_HOST-1:0] v, input logic [31:0] ips [N_HOST]);
		logic [N_HOST:0] f;
		f = '0;
		for (int i = N_HOST - 1; i >= 0; i--) begin
			if (v[i] && ips[i] == ip) begin
				f = {1'b1, N_HOST'(0)} | (N_HOST + 1)'(i);
			end
		end
		return f;
	endfunction

	// interface MAC compare
	logic if_hit;
	always_comb begin
		if_hit = 1'b0;
		for (int i = 0; i < N_IF; i++) begin
			if (if_valid[i] && if_mac[i*48 +: 48] == pkt_dmac)
				if_hit = 1'b1;
		end
	end

	// longest prefix match; ties keep the lower index
	logic lpm_hit;
	logic [31:0] lpm_nh;
	logic [5:0] lpm_len;
	always_comb begin
		lpm_hit = 1'b0;
		lpm_nh = 32'h0000_0000;
		lpm_len = 6'h00;
		for (int i = 0; i < N_ROUTE; i++) begin
			if (r_valid_r[i] && pfx_hit(pkt_dip, r_pfx_r[i], r_len_r[i]) &&
				(!lpm_hit || r_len_r[i] > lpm_len)) begin
				lpm_hit = 1'b1;
				lpm_nh = r_nh_r[i];
				lpm_len = r_len_r[i];
			end
		end
	end

	logic [N_HOST:0] dst_f, nh_f, lrn_f;
	logic [31:0] nh_ip;
	assign dst_f = host_find(pkt_dip, h_valid_r, h_ip_r);
	assign nh_ip = lpm_hit ? lpm_nh : def_next_hop;
	assign nh_f = host_find(nh_ip, h_valid_r, h_ip_r);
	assign lrn_f = host_find(arp_sip, h_valid_r, h_ip_r);

	// free slot for a new learned entry; if none, oldest dynamic one
	logic [$clog2(N_HOST)-1:0] lrn_slot;
	logic lrn_ok;
	always_comb begin
		lrn_slot = '0;
		lrn_ok = 1'b0;
		for (int i = N_HOST - 1; i >= 0; i--) begin
			if (!h_valid_r[i]) begin
				lrn_slot = $clog2(N_HOST)'(i);
				lrn_ok = 1'b1;
			end
		end
		if (!lrn_ok) begin
			for (int i = 0; i < N_HOST; i++) begin
				if (!h_static_r[i] && (!lrn_ok || h_age_r[i] > h_age_r[lrn_slot])) begin
					lrn_slot = $clog2(N_HOST)'(i);
					lrn_ok = 1'b1;
				end
			end
		end
	end

	// route table writes from admin or routing protocol share one port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_valid_r <= '0;
			for (int i = 0; i < N_ROUTE; i++) begin
				r_pfx_r[i] <= 32'h0000_0000;
				r_len_r[i] <= 6'h00;
				r_nh_r[i] <= 32'h0000_0000;
			end
		end else if (rt_wr) begin
			r_valid_r[rt_idx] <= rt_wvalid;
			r_pfx_r[rt_idx] <= rt_prefix;
			r_len_r[rt_idx] <= (rt_len > 6'h20) ? 6'h20 : rt_len;
			r_nh_r[rt_idx] <= rt_next_hop;
		end
	end

	// host table: static writes, learning, ageing; a static write wins the slot
	logic lrn_do;
	logic [$clog2(N_HOST)-1:0] lrn_idx;
	assign lrn_idx = lrn_f[N_HOST] ? lrn_f[$clog2(N_HOST)-1:0] : lrn_slot;
	assign lrn_do = arp_valid && (lrn_f[N_HOST] ? !h_static_r[lrn_idx] : lrn_ok);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			h_valid_r <= '0;
			h_static_r <= '0;
			for (int i = 0; i < N_HOST; i++) begin
				h_ip_r[i] <= 32'h0000_0000;
				h_mac_r[i] <= ZERO_MAC;
				h_age_r[i] <= 64'h0;
			end
		end else begin
			for (int i = 0; i < N_HOST; i++) begin
				if (h_valid_r[i] && !h_static_r[i]) begin
					if (h_age_r[i] >= 64'(AGE_CYCLES) - 64'h1)
						h_valid_r[i] <= 1'b0;
					else
						h_age_r[i] <= h_age_r[i] + 64'h1;
				end
			end
			if (lrn_do && !(host_wr && host_idx == lrn_idx)) begin
				h_valid_r[lrn_idx] <= 1'b1;
				h_static_r[lrn_idx] <= 1'b0;
				h_ip_r[lrn_idx] <= arp_sip;
				h_mac_r[lrn_idx] <= arp_smac;
				h_age_r[lrn_idx] <= 64'h0;
			end
			if (host_wr) begin
				h_valid_r[host_idx] <= host_wvalid;
				h_static_r[host_idx] <= host_wvalid;
				h_ip_r[host_idx] <= host_wip;
				h_mac_r[host_idx] <= host_wmac;
				h_age_r[host_idx] <= 64'h0;
			end
		end
	end

	// lookup decision, one cycle after the header arrives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_valid <= 1'b0;
			res_act <= ACT_BRIDGE;
			res_dmac <= ZERO_MAC;
			res_next_hop <= 32'h0000_0000;
			req_valid <= 1'b0;
			req_tip <= 32'h0000_0000;
			req_dmac <= ZERO_MAC;
		end else begin
			res_valid <= pkt_valid;
			req_valid <= 1'b0;
			res_dmac <= ZERO_MAC;
			res_next_hop <= 32'h0000_0000;
			if (!if_hit) begin
				res_act <= ACT_BRIDGE;
			end else if (dst_f[N_HOST]) begin
				res_act <= ACT_ROUTE;
				res_next_hop <= pkt_dip;
				res_dmac <= h_mac_r[dst_f[$clog2(N_HOST)-1:0]];
			end else if (!lpm_hit && !def_valid) begin
				res_act <= ACT_CPU;
			end else if (nh_f[N_HOST]) begin
				res_act <= ACT_ROUTE;
				res_next_hop <= nh_ip;
				res_dmac <= h_mac_r[nh_f[$clog2(N_HOST)-1:0]];
			end else begin
				// next hop not yet known: ask on the wire, packet is marked ACT_RESOLVE, not ACT_CPU
				res_act <= ACT_RESOLVE;
				res_next_hop <= nh_ip;
				req_valid <= pkt_valid;
				req_tip <= nh_ip;
				req_dmac <= BCAST_MAC;
			end
		end
	end

	a_bridge_no_route: assert property (@(posedge clk) disable iff (!rst_n)
		pkt_valid && !if_hit |=> res_act == ACT_BRIDGE)
		else $error("non-interface MAC was routed");
	a_host_hit_route: assert property (@(posedge clk) disable iff (!rst_n)
		pkt_valid && if_hit && dst_f[N_HOST] |=> res_act == ACT_ROUTE &&
		res_next_hop == $past(pkt_dip))
		else $error("host hit not routed to host");
	a_cpu_no_route: assert property (@(posedge clk) disable iff (!rst_n)
		pkt_valid && if_hit && !dst_f[N_HOST] && !lpm_hit && !def_valid
		|=> res_act == ACT_CPU)
		else $error("unroutable packet not sent to software");
	a_lpm_next_hop: assert property (@(posedge clk) disable iff (!rst_n)
		pkt_valid && if_hit && !dst_f[N_HOST] && lpm_hit
		|=> res_next_hop == $past(lpm_nh))
		else $error("wrong prefix next hop");
	a_default_hop: assert property (@(posedge clk) disable iff (!rst_n)
		pkt_valid && if_hit && !dst_f[N_HOST] && !lpm_hit && def_valid
		|=> res_next_hop == $past(def_next_hop))
		else $error("default route not used");
	a_resolve_bcast: assert property (@(posedge clk) disable iff (!rst_n)
		req_valid |-> req_dmac == BCAST_MAC && res_act == ACT_RESOLVE)
		else $error("resolution request not broadcast");
	a_learn_stores: assert property (@(posedge clk) disable iff (!rst_n)
		lrn_do && !host_wr |=> h_valid_r[$past(lrn_idx)] &&
		h_mac_r[$past(lrn_idx)] == $past(arp_smac))
		else $error("learned entry not stored");
	a_static_kept: assert property (@(posedge clk) disable iff (!rst_n)
		h_valid_r[0] && h_static_r[0] && !host_wr |=> h_valid_r[0] &&
		$stable(h_mac_r[0]))
		else $error("static entry changed");
	a_route_write: assert property (@(posedge clk) disable iff (!rst_n)
		rt_wr |=> r_valid_r[$past(rt_idx)] == $past(rt_wvalid))
		else $error("route write lost");
	c_host_route: cover property (@(posedge clk) res_valid && res_act == ACT_ROUTE);
	c_cpu: cover property (@(posedge clk) res_valid && res_act == ACT_CPU);
	c_resolve: cover property (@(posedge clk) req_valid);
	c_learn: cover property (@(posedge clk) lrn_do && lrn_f[N_HOST]);
endmodule // l3_route_lookup

// ===== rtl/route_pkg.sv
// How it works
// - routing only when destination MAC matches a configured interface MAC
// - on interface match, search host table for destination IP
// - host hit forwards straight to that host, no prefix lookup
// - host miss runs longest prefix match over route table
// - prefix hit uses next hop of most specific matching entry
// - no prefix hit uses default route next hop
// - no prefix hit and no default route sends packet to software
// - route table holds static and protocol-installed entries alike
// - host table holds static and address-resolution-learned entries alike
// - unknown next-hop MAC raises a broadcast resolution request
// - learn sender IP and MAC from resolution requests and replies; an IP whose lowest-index host entry is static is not relearned
// - existing dynamic entry is overwritten with newest learned data
// - dynamic entries not seen within the ageing interval are removed
// - resolved MAC goes into prepended layer-2 destination field
package route_pkg;
	localparam logic [47:0] BCAST_MAC = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] ZERO_MAC = 48'h0000_0000_0000;
	localparam int AGE_TIME_S = 32'h0000_012C;
	// switch clock rate: ticks per second of the ageing counter
	localparam longint CLK_HZ = 64'h0000_0000_0773_5940;
	localparam longint AGE_TICKS = 64'(AGE_TIME_S) * CLK_HZ;
	typedef enum logic [1:0] {
		ACT_BRIDGE = 2'h0,
		ACT_ROUTE = 2'h1,
		ACT_CPU = 2'h2,
		ACT_RESOLVE = 2'h3
	} act_t;
endpackage

// ===== verif/arp_responder.sv
`timescale 1ns/10ps
// far station: answers a broadcast resolution request with a unicast reply; a new request before the reply replaces the pending one
module arp_responder #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [31:0] req_tip,
	input wire logic [47:0] req_dmac,
	output logic arp_valid,
	output logic [31:0] arp_sip,
	output logic [47:0] arp_smac
);
	logic [31:0] tip_r;
	int cnt_r;
	// reply mac is derived from the target ip so the bench can predict it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 0;
			tip_r <= 32'h0;
			arp_valid <= 1'b0;
			arp_sip <= 32'h0;
			arp_smac <= 48'h0;
		end else begin
			arp_valid <= (cnt_r == 1);
			if (cnt_r != 0)
				cnt_r <= cnt_r - 1;
			if (cnt_r == 1) begin
				arp_sip <= tip_r;
				arp_smac <= {16'hA0A0, tip_r};
			end else if (arp_valid) begin
				// released lines must not keep showing the last reply
				arp_sip <= ~arp_sip;
				arp_smac <= ~arp_smac;
			end
			if (req_valid && req_dmac == 48'hFFFF_FFFF_FFFF) begin
				tip_r <= req_tip;
				cnt_r <= DLY;
			end
		end
	end
endmodule // arp_responder

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench
	import route_pkg::*;
;
	localparam logic [47:0] IFM = 48'h0200_0000_0001;
	localparam logic [31:0] H1 = 32'h0A01_0005;
	localparam logic [47:0] M1 = 48'h0000_1111_2222;
	logic clk, rst_n, def_valid, pkt_valid, rt_wr, rt_wvalid, host_wr, host_wvalid;
	logic t_av, p_av, arp_valid, res_valid, req_valid;
	logic [191:0] if_mac;
	logic [3:0] if_valid;
	logic [31:0] def_next_hop, pkt_dip, rt_prefix, rt_next_hop, host_wip, t_sip, p_sip;
	logic [31:0] arp_sip, req_tip, res_next_hop;
	logic [47:0] pkt_dmac, host_wmac, t_smac, p_smac, arp_smac, res_dmac, req_dmac;
	logic [5:0] rt_len;
	logic [2:0] rt_idx, host_idx;
	act_t res_act;
	int n_errors, checks_done;
	// bench learning traffic and partner replies share the resolution input
	assign arp_valid = t_av | p_av;
	assign arp_sip = p_av ? p_sip : t_sip;
	assign arp_smac = p_av ? p_smac : t_smac;
	l3_route_lookup #(.N_IF(4), .N_HOST(8), .N_ROUTE(8), .AGE_CYCLES(20)) dut (.clk(clk),
		.rst_n(rst_n), .if_mac(if_mac), .if_valid(if_valid), .def_valid(def_valid),
		.def_next_hop(def_next_hop), .pkt_valid(pkt_valid), .pkt_dmac(pkt_dmac),
		.pkt_dip(pkt_dip), .rt_wr(rt_wr), .rt_idx(rt_idx), .rt_wvalid(rt_wvalid),
		.rt_prefix(rt_prefix), .rt_len(rt_len), .rt_next_hop(rt_next_hop),
		.host_wr(host_wr), .host_idx(host_idx), .host_wvalid(host_wvalid),
		.host_wip(host_wip), .host_wmac(host_wmac), .arp_valid(arp_valid),
		.arp_sip(arp_sip), .arp_smac(arp_smac), .res_valid(res_valid), .res_act(res_act),
		.res_dmac(res_dmac), .res_next_hop(res_next_hop), .req_valid(req_valid),
		.req_tip(req_tip), .req_dmac(req_dmac));
	arp_responder #(.DLY(3)) far (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_tip(req_tip), .req_dmac(req_dmac), .arp_valid(p_av), .arp_sip(p_sip),
		.arp_smac(p_smac));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic hwr(input logic [2:0] i, input logic [31:0] ip, input logic [47:0] mac);
		{host_wr, host_wvalid, host_idx, host_wip, host_wmac} = {2'b11, i, ip, mac};
		step();
		host_wr = 1'b0;
		step();
	endtask
	task automatic rwr(input logic [2:0] i, input logic [31:0] p, input logic [5:0] l,
		input logic [31:0] nh);
		{rt_wr, rt_wvalid, rt_idx, rt_prefix, rt_len, rt_next_hop} = {2'b11, i, p, l, nh};
		step();
		rt_wr = 1'b0;
		step();
	endtask
	task automatic learn(input logic [31:0] ip, input logic [47:0] mac);
		{t_av, t_sip, t_smac} = {1'b1, ip, mac};
		step();
		{t_av, t_sip, t_smac} = {1'b0, ~ip, ~mac};
		step();
	endtask
	// one header in, result judged in the cycle it stands
	task automatic pkt(input logic [47:0] dm, input logic [31:0] dip, input act_t a,
		input logic [47:0] mac, input logic [31:0] nh);
		{pkt_valid, pkt_dmac, pkt_dip} = {1'b1, dm, dip};
		step();
		pkt_valid = 1'b0;
		chk("res_valid", 48'(res_valid), 48'h1);
		chk("res_act", 48'(res_act), 48'(a));
		chk("req_valid", 48'(req_valid), 48'(a == ACT_RESOLVE));
		if (a == ACT_ROUTE) begin
			chk("res_dmac", res_dmac, mac);
			chk("res_next_hop", 48'(res_next_hop), 48'(nh));
		end else begin
			chk("res_dmac", res_dmac, ZERO_MAC);
		end
		if (a == ACT_RESOLVE) begin
			chk("res_next_hop", 48'(res_next_hop), 48'(nh));
			chk("req_tip", 48'(req_tip), 48'(nh));
			chk("req_dmac", req_dmac, BCAST_MAC);
		end
		// idle edge so the strobe never falls and rises in one time step
		step();
	endtask
	// deleted route and deleted static host must stop attracting traffic
	task automatic t_delete;
		{rt_wr, rt_wvalid, rt_idx} = {2'b10, 3'h1};
		step();
		rt_wr = 1'b0;
		step();
		pkt(IFM, 32'h0A03_0377, ACT_RESOLVE, ZERO_MAC, 32'h0A09_0009);
		{host_wr, host_wvalid, host_idx} = {2'b10, 3'h0};
		step();
		host_wr = 1'b0;
		step();
		pkt(IFM, H1, ACT_RESOLVE, ZERO_MAC, 32'h0A09_0009);
	endtask
	task automatic t_bridge;
		pkt(48'h0200_0000_0002, H1, ACT_BRIDGE, 48'h0, 32'h0);
		pkt(48'h0200_0000_0003, H1, ACT_BRIDGE, 48'h0, 32'h0);
	endtask
	task automatic t_host_lpm;
		hwr(3'h0, H1, M1);
		hwr(3'h1, 32'h0A02_0001, 48'h0000_3333_4444);
		rwr(3'h0, 32'h0A00_0000, 6'h08, 32'h0A09_0009);
		rwr(3'h1, 32'h0A03_0300, 6'h18, 32'h0A02_0001);
		pkt(IFM, H1, ACT_ROUTE, M1, H1);
		pkt(IFM, 32'h0A03_0377, ACT_ROUTE, 48'h0000_3333_4444, 32'h0A02_0001);
		pkt(IFM, 32'h0A04_0001, ACT_RESOLVE, 48'h0, 32'h0A09_0009);
		repeat (5) step();
		pkt(IFM, 32'h0A04_0001, ACT_ROUTE, 48'hA0A0_0A09_0009, 32'h0A09_0009);
	endtask
	task automatic t_default;
		{def_valid, def_next_hop} = {1'b1, H1};
		pkt(IFM, 32'hC0A8_0101, ACT_ROUTE, M1, H1);
		def_valid = 1'b0;
		pkt(IFM, 32'hC0A8_0101, ACT_CPU, 48'h0, 32'h0);
	endtask
	task automatic t_learn_age;
		learn(32'hC0A8_0202, 48'h0000_5555_0001);
		learn(32'hC0A8_0202, 48'h0000_5555_0002);
		{def_valid, def_next_hop} = {1'b1, 32'hC0A8_0202};
		pkt(IFM, 32'hC0A8_0101, ACT_ROUTE, 48'h0000_5555_0002, 32'hC0A8_0202);
		learn(H1, 48'h0000_5555_0009);
		pkt(IFM, H1, ACT_ROUTE, M1, H1);
		repeat (25) step();
		pkt(IFM, 32'hC0A8_0101, ACT_RESOLVE, 48'h0, 32'hC0A8_0202);
		pkt(IFM, H1, ACT_ROUTE, M1, H1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// slot 1 carries a mac but is disabled, so it must not attract routing
	initial begin
		{rst_n, def_valid, pkt_valid, rt_wr, rt_wvalid, host_wr, host_wvalid, t_av} = 8'h00;
		{if_mac, if_valid} = {96'h0, 48'h0200_0000_0002, IFM, 4'h1};
		{def_next_hop, pkt_dip, rt_prefix, rt_next_hop, host_wip, t_sip} = 192'h0;
		{pkt_dmac, host_wmac, t_smac, rt_len, rt_idx, host_idx} = 156'h0;
		n_errors = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		t_bridge();
		t_host_lpm();
		t_default();
		t_learn_age();
		t_delete();
		tally_and_finish();
	end
	// the whole sequence needs about a hundred cycles
	initial begin
		#20000;
		n_errors++;
		tally_and_finish();
	end
endmodule // testbench
